/* File: core/pm_pkg.sv */
// Function
// - Mask-mode 00 off, 10 masks 7 bits, 11 masks 16 bits; 01 never kept.
// - On a 32-bit hart every mask-mode field reads zero and ignores writes.
// - Width field at 1 makes enabling writes for that mode leave the field unchanged.
// - Writing width field 1 clears matching mask-mode bits; going back restores nothing.
// - Supervisor configuration bits 33:32 select masking for user and virtual-user modes.
// - Hypervisor configuration bits 33:32 select masking for virtual-supervisor mode.
// - Hypervisor status bits 49:48 govern user-mode guest accesses done as virtual-user.
// - Guest accesses from hypervisor-supervisor or machine mode as virtual-user use supervisor field.
// - Guest accesses done as virtual-supervisor use the hypervisor configuration field.
// - Guest executable-load accesses are never masked.
// - No masking while make-executable-readable is in effect.
// - Machine configuration bits 33:32 select masking for supervisor mode.
// - Machine security configuration bits 33:32 select masking for machine mode.
// - Virtual modes with bare guest translation use zero-extending physical masking.
// - The two extra guest-physical bits follow the active field under bare translation.
// - Field changes act on the next address with no fence needed.
// - Stage-two fence compares ignore masked upper guest-physical bits.
// - Enabling an unsupported masked-bit count is an ignored write.
// - Address sizes stay within native width minus masked-bit count.
// - Modify-privilege and previous-virtual-privilege select the effective mode's setting.
// - Exception trap value holds the masked address.
package pm_pkg;
  // ==========================================================================
  // Register map, upper words and the width word carry the fields.
  localparam logic [7:0] SENV_LO_OFS = 8'h00;
  localparam logic [7:0] SENV_HI_OFS = 8'h04;
  localparam logic [7:0] HENV_LO_OFS = 8'h08;
  localparam logic [7:0] HENV_HI_OFS = 8'h0C;
  localparam logic [7:0] HSTAT_LO_OFS = 8'h10;
  localparam logic [7:0] HSTAT_HI_OFS = 8'h14;
  localparam logic [7:0] MENV_LO_OFS = 8'h18;
  localparam logic [7:0] MENV_HI_OFS = 8'h1C;
  localparam logic [7:0] MSEC_LO_OFS = 8'h20;
  localparam logic [7:0] MSEC_HI_OFS = 8'h24;
  localparam logic [7:0] WIDTH_OFS = 8'h28;
  // ==========================================================================
  // Field positions inside the upper words and the width word.
  localparam int MODE_POS = 0;
  localparam int UG_MODE_POS = 16;
  localparam int UWID_POS = 0;
  localparam int SWID_POS = 2;
  localparam int MWID_POS = 4;
  // ==========================================================================
  // Encodings, reset values and configuration.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_7 = 2'h2;
  localparam logic [1:0] MODE_16 = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] WID_32 = 2'h1;
  localparam logic [1:0] WID_64 = 2'h2;
  localparam logic [1:0] WID_RESET = 2'h2;
  localparam logic NATIVE_64 = 1'h1;
  localparam logic [1:0] SUPPORTED_MODE_U = 2'h3;
  localparam logic [1:0] SUPPORTED_MODE_S = 2'h3;
  localparam logic [1:0] SUPPORTED_MODE_M = 2'h3;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [63:0] KEEP_57 = 64'h01FF_FFFF_FFFF_FFFF;
  localparam logic [63:0] KEEP_48 = 64'h0000_FFFF_FFFF_FFFF;
endpackage : pm_pkg

/* File: core/pointer_masking_config.sv */
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module pointer_masking_config (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_acc_valid,
  input wire logic [63:0] i_acc_addr,
  input wire logic [1:0] i_cur_priv,
  input wire logic i_cur_virt,
  input wire logic i_modify_privilege,
  input wire logic [1:0] i_prev_priv,
  input wire logic i_prev_virt,
  input wire logic i_guest_ls,
  input wire logic i_guest_exec,
  input wire logic i_supervisor_prev_virt_priv,
  input wire logic i_make_exec_readable,
  input wire logic i_xlate_bare,
  input wire logic i_exc_deliver,
  output logic o_masked_valid,
  output logic [63:0] o_masked_addr,
  output logic [4:0] o_masked_bit_count,
  output logic [63:0] o_trap_value,
  output logic [63:0] o_fence_cmp_mask
);
  logic [1:0] mode_senv;
  logic [1:0] mode_henv;
  logic [1:0] ug_mode;
  logic [1:0] mode_menv;
  logic [1:0] mode_msec;
  logic [1:0] uwid;
  logic [1:0] swid;
  logic [1:0] mwid;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ==========================================================================
  // Bus slave handshakes: each address and data beat is held until both exist.
  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;
  assign o_s_axi_arready = !o_s_axi_rvalid;
  wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take = i_s_axi_wvalid && o_s_axi_wready;
  wire do_write = aw_held && w_held && !o_s_axi_bvalid;
  wire ar_take = i_s_axi_arvalid && o_s_axi_arready;

  // Write decode of the mapped words.
  wire wr_senv = do_write && aw_addr == pm_pkg::SENV_HI_OFS;
  wire wr_henv = do_write && aw_addr == pm_pkg::HENV_HI_OFS;
  wire wr_hstat = do_write && aw_addr == pm_pkg::HSTAT_HI_OFS;
  wire wr_menv = do_write && aw_addr == pm_pkg::MENV_HI_OFS;
  wire wr_msec = do_write && aw_addr == pm_pkg::MSEC_HI_OFS;
  wire wr_wid = do_write && aw_addr == pm_pkg::WIDTH_OFS && w_strb[0];
  wire wr_mapped = aw_addr inside {pm_pkg::SENV_LO_OFS, pm_pkg::SENV_HI_OFS,
    pm_pkg::HENV_LO_OFS, pm_pkg::HENV_HI_OFS, pm_pkg::HSTAT_LO_OFS,
    pm_pkg::HSTAT_HI_OFS, pm_pkg::MENV_LO_OFS, pm_pkg::MENV_HI_OFS,
    pm_pkg::MSEC_LO_OFS, pm_pkg::MSEC_HI_OFS, pm_pkg::WIDTH_OFS};
  wire rd_mapped = i_s_axi_araddr inside {pm_pkg::SENV_LO_OFS, pm_pkg::SENV_HI_OFS,
    pm_pkg::HENV_LO_OFS, pm_pkg::HENV_HI_OFS, pm_pkg::HSTAT_LO_OFS,
    pm_pkg::HSTAT_HI_OFS, pm_pkg::MENV_LO_OFS, pm_pkg::MENV_HI_OFS,
    pm_pkg::MSEC_LO_OFS, pm_pkg::MSEC_HI_OFS, pm_pkg::WIDTH_OFS};

  // ==========================================================================
  // Legal-value filter: returns the old value for any write that is not kept.
  function automatic logic [1:0] legal_mode(input logic [1:0] wr, input logic [1:0] old,
                                            input logic [1:0] wid, input logic [1:0] sup);
    logic [1:0] res;
    res = wr;
    if (wr == pm_pkg::MODE_RSVD) begin
      res = old;
    end
    if (wr != pm_pkg::MODE_OFF && (!pm_pkg::NATIVE_64 || wid == pm_pkg::WID_32)) begin
      res = old;
    end
    if ((wr == pm_pkg::MODE_7 && !sup[0]) || (wr == pm_pkg::MODE_16 && !sup[1])) begin
      res = old;
    end
    return res;
  endfunction : legal_mode

  // Next values, including clearing on a width field switched to 32 bits. The width
  // word is taken from the captured data beat, since the bus may already carry another.
  wire [1:0] next_uwid = wr_wid ? w_data[pm_pkg::UWID_POS +: 2] : uwid;
  wire [1:0] next_swid = wr_wid ? w_data[pm_pkg::SWID_POS +: 2] : swid;
  wire [1:0] next_mwid = wr_wid ? w_data[pm_pkg::MWID_POS +: 2] : mwid;
  wire clr_u = wr_wid && w_data[pm_pkg::UWID_POS +: 2] == pm_pkg::WID_32;
  wire clr_s = wr_wid && w_data[pm_pkg::SWID_POS +: 2] == pm_pkg::WID_32;
  wire clr_m = wr_wid && w_data[pm_pkg::MWID_POS +: 2] == pm_pkg::WID_32;
  wire [1:0] wf_mode = w_data[pm_pkg::MODE_POS +: 2];
  wire [1:0] wf_ug = w_data[pm_pkg::UG_MODE_POS +: 2];
  wire [1:0] next_mode_senv = clr_u ? pm_pkg::MODE_OFF : (wr_senv && w_strb[0]) ?
    legal_mode(wf_mode, mode_senv, uwid, pm_pkg::SUPPORTED_MODE_U) : mode_senv;
  wire [1:0] next_ug_mode = clr_u ? pm_pkg::MODE_OFF : (wr_hstat && w_strb[2]) ?
    legal_mode(wf_ug, ug_mode, uwid, pm_pkg::SUPPORTED_MODE_U) : ug_mode;
  wire [1:0] next_mode_henv = clr_s ? pm_pkg::MODE_OFF : (wr_henv && w_strb[0]) ?
    legal_mode(wf_mode, mode_henv, swid, pm_pkg::SUPPORTED_MODE_S) : mode_henv;
  wire [1:0] next_mode_menv = clr_s ? pm_pkg::MODE_OFF : (wr_menv && w_strb[0]) ?
    legal_mode(wf_mode, mode_menv, swid, pm_pkg::SUPPORTED_MODE_S) : mode_menv;
  wire [1:0] next_mode_msec = clr_m ? pm_pkg::MODE_OFF : (wr_msec && w_strb[0]) ?
    legal_mode(wf_mode, mode_msec, mwid, pm_pkg::SUPPORTED_MODE_M) : mode_msec;

  // Configuration registers; all mask-mode fields start disabled, width fields start at 64 bits.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      mode_senv <= pm_pkg::MODE_RESET;
      mode_henv <= pm_pkg::MODE_RESET;
      ug_mode <= pm_pkg::MODE_RESET;
      mode_menv <= pm_pkg::MODE_RESET;
      mode_msec <= pm_pkg::MODE_RESET;
      uwid <= pm_pkg::WID_RESET;
      swid <= pm_pkg::WID_RESET;
      mwid <= pm_pkg::WID_RESET;
    end else begin
      mode_senv <= next_mode_senv;
      mode_henv <= next_mode_henv;
      ug_mode <= next_ug_mode;
      mode_menv <= next_mode_menv;
      mode_msec <= next_mode_msec;
      uwid <= next_uwid;
      swid <= next_swid;
      mwid <= next_mwid;
    end
  end

  // Write channel capture and response.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= pm_pkg::AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {i_s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_mapped ? pm_pkg::AXI_OKAY : pm_pkg::AXI_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read data mux; lower words and reserved bits read zero.
  wire [7:0] ra = {i_s_axi_araddr[7:2], 2'b00};
  wire [31:0] rd_word =
    ra == pm_pkg::SENV_HI_OFS ? {30'h0, mode_senv} :
    ra == pm_pkg::HENV_HI_OFS ? {30'h0, mode_henv} :
    ra == pm_pkg::HSTAT_HI_OFS ? {14'h0, ug_mode, 16'h0000} :
    ra == pm_pkg::MENV_HI_OFS ? {30'h0, mode_menv} :
    ra == pm_pkg::MSEC_HI_OFS ? {30'h0, mode_msec} :
    ra == pm_pkg::WIDTH_OFS ? {26'h0, mwid, swid, uwid} : 32'h0000_0000;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= pm_pkg::AXI_OKAY;
    end else if (ar_take) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= rd_mapped ? pm_pkg::AXI_OKAY : pm_pkg::AXI_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Effective mode: guest accesses act as virtual, modify-privilege borrows the
  // previous mode while in machine mode.
  wire modpriv_on = i_modify_privilege && i_cur_priv == pm_pkg::PRIV_M;
  wire [1:0] eff_priv = i_guest_ls ? (i_supervisor_prev_virt_priv ? pm_pkg::PRIV_S :
    pm_pkg::PRIV_U) : modpriv_on ? i_prev_priv : i_cur_priv;
  wire eff_virt = i_guest_ls ? 1'b1 : modpriv_on ? i_prev_virt : i_cur_virt;

  // Field selection; values come straight from registers, so a change acts at once.
  wire [1:0] sel_mode =
    (i_guest_exec || i_make_exec_readable) ? pm_pkg::MODE_OFF :
    eff_priv == pm_pkg::PRIV_M ? mode_msec :
    (eff_priv == pm_pkg::PRIV_S && !eff_virt) ? mode_menv :
    (eff_priv == pm_pkg::PRIV_S) ? mode_henv :
    (eff_virt && i_guest_ls && i_cur_priv == pm_pkg::PRIV_U) ? ug_mode :
    mode_senv;

  // Physical addresses zero-fill; bare guest translation counts as physical,
  // which also masks the two extra guest-physical bits.
  wire is_phys = i_xlate_bare || eff_priv == pm_pkg::PRIV_M;
  wire [63:0] next_masked =
    sel_mode == pm_pkg::MODE_7 ? (is_phys ? i_acc_addr & pm_pkg::KEEP_57 :
      {{7{i_acc_addr[56]}}, i_acc_addr[56:0]}) :
    sel_mode == pm_pkg::MODE_16 ? (is_phys ? i_acc_addr & pm_pkg::KEEP_48 :
      {{16{i_acc_addr[47]}}, i_acc_addr[47:0]}) : i_acc_addr;
  wire [4:0] next_count = sel_mode == pm_pkg::MODE_7 ? 5'h07 :
    sel_mode == pm_pkg::MODE_16 ? 5'h10 : 5'h00;

  // Stage-two fence compare mask drops the masked upper guest-physical bits.
  assign o_fence_cmp_mask = mode_henv == pm_pkg::MODE_7 ? pm_pkg::KEEP_57 :
    mode_henv == pm_pkg::MODE_16 ? pm_pkg::KEEP_48 : 64'hFFFF_FFFF_FFFF_FFFF;

  // Address result and trap value registers.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_masked_valid <= 1'b0;
      o_masked_addr <= 64'h0000_0000_0000_0000;
      o_masked_bit_count <= 5'h00;
      o_trap_value <= 64'h0000_0000_0000_0000;
    end else begin
      o_masked_valid <= i_acc_valid;
      if (i_acc_valid) begin
        o_masked_addr <= next_masked;
        o_masked_bit_count <= next_count;
      end
      if (i_exc_deliver) begin
        o_trap_value <= next_masked;
      end
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_wid32_write;
    wr_wid && w_data[pm_pkg::UWID_POS +: 2] == pm_pkg::WID_32;
  endsequence
  a_rsvd_never_kept: assert property (mode_senv != pm_pkg::MODE_RSVD
    && mode_henv != pm_pkg::MODE_RSVD && ug_mode != pm_pkg::MODE_RSVD
    && mode_menv != pm_pkg::MODE_RSVD && mode_msec != pm_pkg::MODE_RSVD)
    else $error("Reserved mask mode retained.");
  a_u32_blocks_enable: assert property (uwid == pm_pkg::WID_32 && !clr_u
    |=> $stable(mode_senv) || mode_senv == pm_pkg::MODE_OFF)
    else $error("Enable accepted at 32-bit width.");
  a_width_clears: assert property (s_wid32_write |=>
    mode_senv == pm_pkg::MODE_OFF && ug_mode == pm_pkg::MODE_OFF)
    else $error("Width change did not clear field.");
  a_exec_unmasked: assert property (i_acc_valid && i_guest_exec |=>
    o_masked_addr == $past(i_acc_addr) && o_masked_bit_count == 5'h00)
    else $error("Executable load was masked.");
  a_xrd_unmasked: assert property (i_acc_valid && i_make_exec_readable |=>
    o_masked_bit_count == 5'h00) else $error("Masking under exec-readable.");
  a_mmode_field: assert property (i_acc_valid && !i_guest_ls && !modpriv_on
    && !i_guest_exec && !i_make_exec_readable && i_cur_priv == pm_pkg::PRIV_M
    && mode_msec == pm_pkg::MODE_7 |=> o_masked_bit_count == 5'h07)
    else $error("Machine field not applied.");
  a_phys_zero_fill: assert property (i_acc_valid && is_phys
    && sel_mode == pm_pkg::MODE_16 |=> o_masked_addr[63:48] == 16'h0000)
    else $error("Physical mask not zeroed.");
  a_trap_masked: assert property (i_exc_deliver && i_acc_valid |=>
    o_trap_value == o_masked_addr) else $error("Trap value not masked.");
  a_write_answer: assert property (do_write |=> o_s_axi_bvalid)
    else $error("Write not answered.");
endmodule : pointer_masking_config

/* File: testbench/hart_access_model.sv */
// ============================================================================
// Hart side: issues one explicit data access at a time, with its mode bits.
module hart_access_model (
  input wire logic i_sys_clk,
  output logic o_acc_valid,
  output logic [63:0] o_acc_addr,
  output logic [1:0] o_cur_priv,
  output logic o_cur_virt,
  output logic o_modify_privilege,
  output logic [1:0] o_prev_priv,
  output logic o_prev_virt,
  output logic o_guest_ls,
  output logic o_guest_exec,
  output logic o_supervisor_prev_virt_priv,
  output logic o_make_exec_readable,
  output logic o_xlate_bare,
  output logic o_exc_deliver
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle state; the previous mode is user, so modify-privilege selects user.
  initial begin
    {o_acc_valid, o_acc_addr, o_cur_priv, o_cur_virt, o_modify_privilege} = '0;
    {o_prev_priv, o_prev_virt, o_guest_ls, o_guest_exec} = '0;
    {o_supervisor_prev_virt_priv, o_make_exec_readable, o_xlate_bare, o_exc_deliver} = '0;
  end

  // One access pulse; the address line is scrambled once the request is gone.
  task automatic issue(input logic [1:0] pr, input logic vi, input logic [5:0] fl,
                       input logic [63:0] a, input logic exc);
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b1;
    o_acc_addr <= a;
    o_cur_priv <= pr;
    o_cur_virt <= vi;
    o_modify_privilege <= fl[5];
    o_guest_ls <= fl[4];
    o_guest_exec <= fl[3];
    o_supervisor_prev_virt_priv <= fl[2];
    o_make_exec_readable <= fl[1];
    o_xlate_bare <= fl[0];
    o_exc_deliver <= exc;
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b0;
    o_exc_deliver <= 1'b0;
    o_acc_addr <= ~a;
    #1;
  endtask : issue
endmodule : hart_access_model

/* File: testbench/pointer_masking_config_test.sv */
module pointer_masking_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = pm_pkg::AXI_OKAY;
  localparam logic [1:0] U = pm_pkg::PRIV_U;
  localparam logic [1:0] S = pm_pkg::PRIV_S;
  localparam logic [1:0] M = pm_pkg::PRIV_M;
  localparam logic [5:0] MODP = 6'h20;
  localparam logic [5:0] GLS = 6'h10;
  localparam logic [5:0] GEX = 6'h18;
  localparam logic [5:0] SVPV = 6'h04;
  localparam logic [5:0] XRD = 6'h02;
  localparam logic [5:0] BARE = 6'h01;
  localparam logic [63:0] ADR = 64'hA5C3_F0F0_8765_4321;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, masked_valid;
  logic [1:0] bresp, rresp;
  logic [63:0] masked_addr, trap_value, fence_cmp_mask;
  logic [4:0] masked_bit_count;
  logic acc_valid, cur_virt, modpriv, prev_virt, gls, gex, svpv, xrd, bare, exc;
  logic [63:0] acc_addr;
  logic [1:0] cur_priv, prev_priv;
  logic [1:0] code [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  logic [1:0] kept [4] = '{2'h2, 2'h3, 2'h3, 2'h0};
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  pointer_masking_config pointer_masking_config_i (.i_sys_clk(clk), .i_nrst(nrst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_acc_valid(acc_valid),
    .i_acc_addr(acc_addr), .i_cur_priv(cur_priv), .i_cur_virt(cur_virt),
    .i_modify_privilege(modpriv), .i_prev_priv(prev_priv), .i_prev_virt(prev_virt),
    .i_guest_ls(gls), .i_guest_exec(gex), .i_supervisor_prev_virt_priv(svpv),
    .i_make_exec_readable(xrd), .i_xlate_bare(bare), .i_exc_deliver(exc),
    .o_masked_valid(masked_valid), .o_masked_addr(masked_addr),
    .o_masked_bit_count(masked_bit_count), .o_trap_value(trap_value),
    .o_fence_cmp_mask(fence_cmp_mask));

  hart_access_model hart_access_model_i (.i_sys_clk(clk), .o_acc_valid(acc_valid),
    .o_acc_addr(acc_addr), .o_cur_priv(cur_priv), .o_cur_virt(cur_virt),
    .o_modify_privilege(modpriv), .o_prev_priv(prev_priv), .o_prev_virt(prev_virt),
    .o_guest_ls(gls), .o_guest_exec(gex), .o_supervisor_prev_virt_priv(svpv),
    .o_make_exec_readable(xrd), .o_xlate_bare(bare), .o_exc_deliver(exc));

  // ==========================================================================
  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  // ==========================================================================
  // Compare, mask arithmetic and bus tasks.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Virtual form copies the top kept bit upward; physical form zero-fills.
  function automatic logic [63:0] msk(input logic [63:0] a, input int n, input logic ph);
    logic [63:0] keep;
    keep = 64'hFFFF_FFFF_FFFF_FFFF >> n;
    return (!ph && a[63 - n]) ? (a | ~keep) : (a & keep);
  endfunction : msk

  // Address and data are offered together and each is dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(64'(bresp), 64'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(64'(rdata), 64'(exp));
    chk(64'(rresp), 64'(er));
  endtask : rd

  task automatic acc(input logic [1:0] pr, input logic vi, input logic [5:0] fl,
                     input int n, input logic ph);
    hart_access_model_i.issue(pr, vi, fl, ADR, 1'b0);
    chk(masked_addr, msk(ADR, n, ph));
    chk(64'(masked_bit_count), 64'(n));
    chk(64'(masked_valid), 64'h1);
  endtask : acc

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Main sequence.
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(8 * i + 4), 32'h0, OK);
    rd(pm_pkg::WIDTH_OFS, 32'h0000_002A, OK);
    $display("Test reset values done");
    wr(pm_pkg::SENV_LO_OFS, 32'hFFFF_FFFF, OK);
    rd(pm_pkg::SENV_LO_OFS, 32'h0, OK);
    wr(8'h30, 32'h3, pm_pkg::AXI_SLVERR);
    rd(8'h30, 32'h0, pm_pkg::AXI_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(pm_pkg::SENV_HI_OFS, 32'(code[i]), OK);
      rd(pm_pkg::SENV_HI_OFS, 32'(kept[i]), OK);
    end
    $display("Test field codes done");
    // User and non-virtual supervisor fields take 16 masked bits, the hypervisor, guest-user and machine fields 7, so selection paths differ.
    wr(pm_pkg::SENV_HI_OFS, 32'h3, OK);
    wr(pm_pkg::HENV_HI_OFS, 32'h2, OK);
    wr(pm_pkg::HSTAT_HI_OFS, 32'h0002_0000, OK);
    wr(pm_pkg::MENV_HI_OFS, 32'h3, OK);
    wr(pm_pkg::MSEC_HI_OFS, 32'h2, OK);
    chk(fence_cmp_mask, 64'hFFFF_FFFF_FFFF_FFFF >> 7);
    acc(U, 1'b0, 6'h00, 16, 1'b0);
    acc(U, 1'b1, 6'h00, 16, 1'b0);
    acc(U, 1'b1, BARE, 16, 1'b1);
    acc(S, 1'b0, 6'h00, 16, 1'b0);
    acc(S, 1'b1, 6'h00, 7, 1'b0);
    acc(M, 1'b0, 6'h00, 7, 1'b1);
    acc(M, 1'b0, MODP, 16, 1'b0);
    acc(U, 1'b0, GLS, 7, 1'b0);
    acc(S, 1'b0, GLS, 16, 1'b0);
    acc(S, 1'b0, GLS | SVPV, 7, 1'b0);
    acc(S, 1'b0, GEX, 0, 1'b0);
    acc(U, 1'b0, XRD, 0, 1'b0);
    wr(pm_pkg::SENV_HI_OFS, 32'h0, OK);
    acc(U, 1'b0, 6'h00, 0, 1'b0);
    // Hypervisor copies the guest's supervisor field before user-mode guest accesses.
    wr(pm_pkg::HSTAT_HI_OFS, 32'h0000_0000, OK);
    acc(U, 1'b0, GLS, 0, 1'b0);
    hart_access_model_i.issue(M, 1'b0, 6'h00, ADR, 1'b1);
    chk(trap_value, msk(ADR, 7, 1'b1));
    $display("Test access selection done");
    wr(pm_pkg::SENV_HI_OFS, 32'h3, OK);
    // A change of the hypervisor field to 16 masked bits changes the stage-two fence compare mask at once.
    wr(pm_pkg::HENV_HI_OFS, 32'h3, OK);
    chk(fence_cmp_mask, 64'hFFFF_FFFF_FFFF_FFFF >> 16);
    wr(pm_pkg::WIDTH_OFS, 32'h0000_0015, OK);
    rd(pm_pkg::WIDTH_OFS, 32'h0000_0015, OK);
    for (int i = 0; i < 5; i++) rd(8'(8 * i + 4), 32'h0, OK);
    chk(fence_cmp_mask, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(pm_pkg::SENV_HI_OFS, 32'h3, OK);
    rd(pm_pkg::SENV_HI_OFS, 32'h0, OK);
    wr(pm_pkg::WIDTH_OFS, 32'h0000_002A, OK);
    rd(pm_pkg::SENV_HI_OFS, 32'h0, OK);
    $display("Test width fields done");
    close_out();
  end
endmodule : pointer_masking_config_test
